// ===== hw/icu_pkg.sv
package icu_pkg;

    // Register bus geometry
    localparam int unsigned ICU_ADDR_W = 8;
    localparam int unsigned ICU_DATA_W = 32;

    // Register byte addresses, one aligned word each
    localparam logic [7:0] ICU_OFS_CONTROL = 8'h00;
    localparam logic [7:0] ICU_OFS_VALUE_LOW = 8'h04;
    localparam logic [7:0] ICU_OFS_VALUE_HIGH = 8'h08;
    localparam logic [7:0] ICU_OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ICU_OFS_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ICU_OFS_IRQ_ENABLE = 8'h14;

    // Field positions
    localparam int unsigned ICU_MODE_LSB = 0;
    localparam int unsigned ICU_MODE_MSB = 3;
    localparam int unsigned ICU_FLAG_BIT = 0;

    // Reset values
    localparam logic [7:0] ICU_CONTROL_RST = 8'h00;
    localparam logic [7:0] ICU_VALUE_RST = 8'h00;
    localparam logic ICU_FLAG_RST = 1'b0;
    localparam logic ICU_ENABLE_RST = 1'b0;

    // Mode select field encodings
    localparam logic [3:0] ICU_MODE_OFF = 4'h0;
    localparam logic [3:0] ICU_MODE_FALL = 4'h4;
    localparam logic [3:0] ICU_MODE_RISE = 4'h5;
    localparam logic [3:0] ICU_MODE_RISE4 = 4'h6;
    localparam logic [3:0] ICU_MODE_RISE16 = 4'h7;

    // Prescaler: fire when the masked count is all ones
    localparam int unsigned ICU_PRESCALE_W = 4;
    localparam logic [3:0] ICU_DIV4_MASK = 4'h3;
    localparam logic [3:0] ICU_DIV16_MASK = 4'hf;
    localparam logic [3:0] ICU_PRESCALE_RST = 4'h0;

    // Pin synchroniser depth
    localparam int unsigned ICU_SYNC_STAGES = 2;

    // Decoded capture event selection
    typedef enum logic [2:0] {
        ICU_SEL_NONE,
        ICU_SEL_FALL,
        ICU_SEL_RISE,
        ICU_SEL_RISE4,
        ICU_SEL_RISE16
    } icu_sel_e;

    // Sixteen-bit timebase count, high and low bytes together
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } icu_count_s;

    // Mode field to event selection; anything else is not capture
    function automatic icu_sel_e icu_decode_mode(input logic [3:0] mode);
        icu_sel_e sel;
        sel = ICU_SEL_NONE;
        case (mode)
            ICU_MODE_FALL: sel = ICU_SEL_FALL;
            ICU_MODE_RISE: sel = ICU_SEL_RISE;
            ICU_MODE_RISE4: sel = ICU_SEL_RISE4;
            ICU_MODE_RISE16: sel = ICU_SEL_RISE16;
            default: sel = ICU_SEL_NONE;
        endcase
        return sel;
    endfunction : icu_decode_mode

endpackage : icu_pkg

// ===== hw/icu_edge_prescale.sv
`timescale 1ns/100ps
module icu_edge_prescale (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Capture pin level
    input wire logic pin_in,
    // Selection from the mode field
    input icu_pkg::icu_sel_e sel,
    // Event out, one cycle per selected event
    output logic fire
);
    import icu_pkg::*;

    logic sync1_reg;                        // First stage, read only by sync2_reg
    logic sync2_reg;                        // Settled pin level
    logic prev_reg;                         // Level one cycle earlier
    logic [ICU_PRESCALE_W-1:0] cnt_reg;     // Rising edge prescaler
    logic [ICU_PRESCALE_W-1:0] cnt_next;
    logic rise;
    logic fall;
    logic in_capture;
    logic div4_hit;
    logic div16_hit;

    // Two-stage synchroniser plus edge history
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;        // [R5]
            sync2_reg <= sync1_reg;     // [R17]
            prev_reg <= sync2_reg;
        end
    end

    // Edges on the settled level only, so one edge gives one pulse
    assign rise = sync2_reg & ~prev_reg;    // [R17]
    assign fall = ~sync2_reg & prev_reg;    // [R17]
    assign in_capture = (sel != ICU_SEL_NONE);

    // Held clear outside capture; a switch between capture settings keeps it
    assign cnt_next = !in_capture ? ICU_PRESCALE_RST :        // [R10]
                      rise ? cnt_reg + 4'h1 : cnt_reg;        // [R12]

    // Counter register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= ICU_PRESCALE_RST;    // [R11]
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Fourth and sixteenth rising edges
    assign div4_hit = ((cnt_reg & ICU_DIV4_MASK) == ICU_DIV4_MASK);
    assign div16_hit = ((cnt_reg & ICU_DIV16_MASK) == ICU_DIV16_MASK);

    // Event selection
    assign fire = (sel == ICU_SEL_FALL) ? fall :                 // [R2]
                  (sel == ICU_SEL_RISE) ? rise :                 // [R2]
                  (sel == ICU_SEL_RISE4) ? (rise & div4_hit) :   // [R2]
                  (sel == ICU_SEL_RISE16) ? (rise & div16_hit) : // [R2]
                  1'b0;

    property p_prescale_cleared;
        @(posedge core_clk) disable iff (!rst_n)
        !in_capture |=> (cnt_reg == ICU_PRESCALE_RST);
    endproperty
    a_prescale_cleared: assert property (p_prescale_cleared) // [R10]
        else $error("prescaler not cleared outside capture");

    property p_prescale_kept;
        @(posedge core_clk) disable iff (!rst_n)
        (in_capture && !rise) |=> (cnt_reg == $past(cnt_reg));
    endproperty
    a_prescale_kept: assert property (p_prescale_kept) // [R12]
        else $error("prescaler changed without a rising edge");

    property p_sixteenth;
        @(posedge core_clk) disable iff (!rst_n)
        (sel == ICU_SEL_RISE16 && rise) |-> (fire == (cnt_reg == 4'hf));
    endproperty
    a_sixteenth: assert property (p_sixteenth) // [R2]
        else $error("divide by sixteen fired on wrong edge");

    property p_single_pulse;
        @(posedge core_clk) disable iff (!rst_n)
        fire |=> !fire;
    endproperty
    a_single_pulse: assert property (p_single_pulse) // [R17]
        else $error("event pulse longer than one cycle");

endmodule : icu_edge_prescale

// ===== hw/icu_top.sv
// How it works
// [R1] Event copies both timebase bytes at once
// [R2] Falling, rising, fourth, sixteenth rising edge
// [R3] Capture sets sticky flag; software clears it
// [R4] Newer capture overwrites unread value
// [R5] Pin level sensed whatever its direction
// [R6] Software keeps capture pin an input
// [R7] Software uses timer or synchronous counter
// [R8] Software never clocks timebase from undivided clock
// [R9] Mode change may set a false flag
// [R10] Prescaler held clear when not capturing
// [R11] Every reset clears the prescaler
// [R12] Prescale switch does not clear the counter
// [R13] Software writes zero, then new mode
// [R14] Quarter-rate timebase halts in sleep, resumes
// [R15] External timebase keeps capture alive in sleep
// [R16] Mode codes 0000 off, 0100 to 0111
// [R17] Synchronise pin, detect edges, one capture each
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module icu_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Capture pin, sensed as driven or as received
    input wire logic capture_pin_in,
    // Timebase counter interface
    input icu_pkg::icu_count_s timebase_count,
    input wire logic timebase_ext_clock,
    output logic timebase_count_enable,
    // Power state
    input wire logic sleep_active,
    // Interrupt
    output logic irq
);
    import icu_pkg::*;

    // Register state
    logic [7:0] control_reg;        // capture_control
    logic [7:0] control_next;
    icu_count_s value_reg;          // capture_value_high and capture_value_low
    icu_count_s value_next;
    logic flag_reg;                 // capture_event_flag
    logic flag_next;
    logic enable_reg;               // capture_irq_enable
    logic enable_next;

    // Bus decode
    logic access;                   // Access phase, always completes at once
    logic wr;
    logic lane0;                    // Byte lane holding the 8-bit registers
    logic hit_control;
    logic hit_low;
    logic hit_high;
    logic hit_status;
    logic hit_clear;
    logic hit_enable;
    logic addr_hit;

    // Capture datapath
    logic [3:0] mode_select_field;
    icu_sel_e sel;
    logic raw_fire;                 // Event from the edge and prescale stage
    logic sleep_ok;                 // Capture allowed in the present power state
    logic capture_fire;             // Event that really latches
    logic flag_clear;

    // The slave never stretches a transfer
    assign pready = 1'b1;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign lane0 = pstrb[0];

    // Address decode
    assign hit_control = (paddr == ICU_OFS_CONTROL);
    assign hit_low = (paddr == ICU_OFS_VALUE_LOW);
    assign hit_high = (paddr == ICU_OFS_VALUE_HIGH);
    assign hit_status = (paddr == ICU_OFS_IRQ_STATUS);
    assign hit_clear = (paddr == ICU_OFS_IRQ_CLEAR);
    assign hit_enable = (paddr == ICU_OFS_IRQ_ENABLE);
    assign addr_hit = hit_control | hit_low | hit_high | hit_status | hit_clear | hit_enable;

    // Unmapped addresses answer with an error and have no effect
    assign pslverr = access & ~addr_hit;

    // Mode field and its decode
    assign mode_select_field = control_reg[ICU_MODE_MSB:ICU_MODE_LSB];
    assign sel = icu_decode_mode(mode_select_field);  // [R16]

    // Edge detection and prescaling
    icu_edge_prescale u_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(capture_pin_in),
        .sel(sel),
        .fire(raw_fire)
    );

    // Quarter-rate timebase stops in sleep; external one keeps running
    assign timebase_count_enable = ~(sleep_active & ~timebase_ext_clock);  // [R14]

    // In sleep only an external timebase gives meaningful captures
    assign sleep_ok = ~sleep_active | timebase_ext_clock;  // [R15]
    assign capture_fire = raw_fire & sleep_ok;              // [R15]

    // Control: whole byte stored, low nibble drives the mode
    assign control_next = (wr && hit_control && lane0) ? pwdata[7:0] : control_reg;

    // Capture has priority over a software write in the same cycle;
    // both bytes load together, so a stale value is simply replaced
    assign value_next.high = capture_fire ? timebase_count.high :                   // [R1]
                             (wr && hit_high && lane0) ? pwdata[7:0] : value_reg.high;
    assign value_next.low = capture_fire ? timebase_count.low :                     // [R1]
                            (wr && hit_low && lane0) ? pwdata[7:0] : value_reg.low; // [R4]

    // Sticky flag: set wins over a clear in the same cycle
    assign flag_clear = wr && hit_clear && lane0 && pwdata[ICU_FLAG_BIT];
    assign flag_next = capture_fire | (flag_reg & ~flag_clear);  // [R3]

    // Interrupt enable
    assign enable_next = (wr && hit_enable && lane0) ? pwdata[ICU_FLAG_BIT] : enable_reg;

    // Register update
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= ICU_CONTROL_RST;
            value_reg <= {ICU_VALUE_RST, ICU_VALUE_RST};
            flag_reg <= ICU_FLAG_RST;
            enable_reg <= ICU_ENABLE_RST;
        end else begin
            control_reg <= control_next;
            value_reg <= value_next;
            flag_reg <= flag_next;
            enable_reg <= enable_next;
        end
    end

    // Level interrupt while an enabled status bit is set
    assign irq = flag_reg & enable_reg;  // [R9]

    // Read mux; clear register and unmapped addresses read zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            if (hit_control) begin
                prdata[7:0] = control_reg;
            end else if (hit_low) begin
                prdata[7:0] = value_reg.low;
            end else if (hit_high) begin
                prdata[7:0] = value_reg.high;
            end else if (hit_status) begin
                prdata[ICU_FLAG_BIT] = flag_reg;
            end else if (hit_enable) begin
                prdata[ICU_FLAG_BIT] = enable_reg;
            end else begin
                prdata = 32'h0000_0000;
            end
        end
    end

    // A capture event and the value it leaves behind
    sequence s_event;
        capture_fire;
    endsequence

    // Value one edge later equals the count seen with the event
    sequence s_latched;
        ##1 (value_reg == $past(timebase_count));
    endsequence

    // Both bytes come from one sample, so the pair never tears
    property p_capture_copies;
        @(posedge core_clk) disable iff (!rst_n)
        s_event |-> s_latched;
    endproperty
    a_capture_copies: assert property (p_capture_copies) // [R1]
        else $error("captured value differs from timebase");

    // No overrun guard: the newest capture always wins
    property p_overwrite;
        @(posedge core_clk) disable iff (!rst_n)
        (capture_fire ##[1:16] capture_fire) |=> (value_reg == $past(timebase_count));
    endproperty
    a_overwrite: assert property (p_overwrite) // [R4]
        else $error("second capture did not replace first");

    // Every capture raises the flag one edge later
    property p_flag_set;
        @(posedge core_clk) disable iff (!rst_n)
        s_event |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) // [R3]
        else $error("capture did not set the flag");

    // Only a software clear drops the flag
    property p_flag_sticky;
        @(posedge core_clk) disable iff (!rst_n)
        (flag_reg && !flag_clear) |=> flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [R3]
        else $error("flag dropped without a clear");

    // A clear with no capture beside it takes effect
    property p_flag_cleared;
        @(posedge core_clk) disable iff (!rst_n)
        (flag_clear && !capture_fire) |=> !flag_reg;
    endproperty
    a_flag_cleared: assert property (p_flag_cleared) // [R3]
        else $error("flag clear had no effect");

    // Interrupt is a plain level, masked by the enable bit
    property p_irq_level;
        @(posedge core_clk) disable iff (!rst_n)
        irq == (flag_reg && enable_reg);
    endproperty
    a_irq_level: assert property (p_irq_level) // [R9]
        else $error("interrupt does not follow enabled flag");

    // Module off means no capture at all
    property p_off_no_capture;
        @(posedge core_clk) disable iff (!rst_n)
        (mode_select_field == ICU_MODE_OFF) |-> !capture_fire;
    endproperty
    a_off_no_capture: assert property (p_off_no_capture) // [R16]
        else $error("capture while module off");

    // Quarter-rate timebase frozen and captures blocked in sleep
    property p_sleep_halt;
        @(posedge core_clk) disable iff (!rst_n)
        (sleep_active && !timebase_ext_clock) |-> (!timebase_count_enable && !capture_fire);
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) // [R14]
        else $error("quarter-rate timebase active in sleep");

    // External timebase keeps capture working in sleep
    property p_sleep_external;
        @(posedge core_clk) disable iff (!rst_n)
        (timebase_ext_clock && raw_fire) |=> (value_reg == $past(timebase_count)) && flag_reg;
    endproperty
    a_sleep_external: assert property (p_sleep_external) // [R15]
        else $error("external timebase capture lost");

    // Value only moves on a capture or a software write
    property p_value_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (!capture_fire && !(wr && (hit_low || hit_high))) |=> $stable(value_reg);
    endproperty
    a_value_hold: assert property (p_value_hold) // [R1]
        else $error("captured value changed without cause");

    // Set beats clear when both land in one cycle, so no event is lost
    property p_set_beats_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (capture_fire && flag_clear) |=> flag_reg;
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) // [R3]
        else $error("clear beat a capture in the same cycle");

    // A capture needs a capture mode and a power state that allows it
    property p_fire_needs_mode;
        @(posedge core_clk) disable iff (!rst_n)
        capture_fire |-> ((sel != ICU_SEL_NONE) && sleep_ok);
    endproperty
    a_fire_needs_mode: assert property (p_fire_needs_mode) // [R16]
        else $error("capture outside a capture mode");

    // A control write lands whole at its access edge
    property p_control_write;
        @(posedge core_clk) disable iff (!rst_n)
        (wr && hit_control && lane0) |=> (control_reg == $past(pwdata[7:0]));
    endproperty
    a_control_write: assert property (p_control_write) // [R16]
        else $error("control write did not land");

    // Pin rise to flag: two synchroniser edges, then the latch edge
    sequence s_pin_rise;
        $rose(capture_pin_in) ##2 ((sel == ICU_SEL_RISE) && sleep_ok);
    endsequence

    property p_pin_to_flag;
        @(posedge core_clk) disable iff (!rst_n)
        s_pin_rise |=> flag_reg;
    endproperty
    a_pin_to_flag: assert property (p_pin_to_flag) // [R17]
        else $error("rising pin did not raise the flag");

    // Pin fall to value in falling-edge mode, same latency
    sequence s_pin_fall;
        $fell(capture_pin_in) ##2 ((sel == ICU_SEL_FALL) && sleep_ok);
    endsequence

    property p_pin_fall_latch;
        @(posedge core_clk) disable iff (!rst_n)
        s_pin_fall |=> (value_reg == $past(timebase_count));
    endproperty
    a_pin_fall_latch: assert property (p_pin_fall_latch) // [R2]
        else $error("falling pin did not latch the timebase");

endmodule : icu_top

// ===== verification/icu_pin_model.sv
`timescale 1ns/100ps
module icu_pin_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Timebase enable from the block, preset from the bench
    input wire logic count_enable,
    input wire logic [15:0] preset,
    // Pin level and timebase value
    output logic pin,
    output icu_pkg::icu_count_s timebase
);
    import icu_pkg::*;

    // Pin idles low until the bench moves it
    initial pin = 1'b0;

    // Timer mode off the instruction clock; frozen, not cleared, when disabled
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timebase <= preset;
        end else if (count_enable) begin
            timebase <= icu_count_s'(timebase + 16'd1);
        end
    end

    // New level, held three edges; shorter levels could slip the synchroniser
    task automatic set_pin(input logic lvl, output logic [15:0] snap);
        @(posedge core_clk);
        snap = timebase;
        pin <= lvl;
        repeat (3) @(posedge core_clk);
    endtask : set_pin
endmodule : icu_pin_model

// ===== verification/input_capture_unit_tb_top.sv
`timescale 1ns/100ps
module input_capture_unit_tb_top;
    import icu_pkg::*;

    // Bus, pin and power signals
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic sleep_active, ext_clk, cnt_en, pin, er, lvl;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd, lfsr;
    logic [15:0] preset, exp_val;
    icu_count_s tb_count;
    int n_fail, checks_done;

    // Device under test
    icu_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_pin_in(pin), .timebase_count(tb_count),
        .timebase_ext_clock(ext_clk), .timebase_count_enable(cnt_en),
        .sleep_active(sleep_active), .irq(irq));

    // Far side: pin source and timebase
    icu_pin_model i_far (.core_clk(core_clk), .rst_n(rst_n), .count_enable(cnt_en),
        .preset(preset), .pin(pin), .timebase(tb_count));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Galois shift register step for random data
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : next_rand

    // Compare, count, report at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // Only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read and compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk

    // Flag and irq checks; irq looked at once the edge has settled
    task automatic flag_chk(input logic f);
        rchk(ICU_OFS_IRQ_STATUS, {31'h0, f});
    endtask : flag_chk
    task automatic irq_chk(input logic f);
        @(negedge core_clk);
        chk({31'h0, irq}, {31'h0, f});
    endtask : irq_chk

    // Both captured bytes against the expected timebase
    task automatic val_chk();
        rchk(ICU_OFS_VALUE_LOW, {24'h0, exp_val[7:0]});
        rchk(ICU_OFS_VALUE_HIGH, {24'h0, exp_val[15:8]});
    endtask : val_chk

    // Pin to a level; capture would hold the timebase three edges on
    task automatic edge_to(input logic l);
        logic [15:0] c;
        i_far.set_pin(l, c);
        exp_val = c + 16'd3;
    endtask : edge_to
    task automatic rises(input int n);
        repeat (n) begin
            edge_to(1'b0);
            edge_to(1'b1);
        end
    endtask : rises

    // Off first, then the mode, then drop any false flag
    task automatic set_mode(input logic [3:0] m);
        apb(1'b1, ICU_OFS_CONTROL, 32'h0);
        apb(1'b1, ICU_OFS_CONTROL, {28'h0, m});
        apb(1'b1, ICU_OFS_IRQ_CLEAR, 32'h1);
    endtask : set_mode

    // Verdict and end of run
    task automatic stop_test();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // Hang guard, well past the several hundred cycles the tests need
    initial begin
        repeat (30000) @(posedge core_clk);
        n_fail++;
        stop_test();
    end

    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, sleep_active, ext_clk} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        n_fail = 0;
        checks_done = 0;
        lfsr = 32'h3ea69e9d;
        preset = 16'h00fd;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values, read-only status, unmapped address, value as RW
        rchk(ICU_OFS_CONTROL, 32'h0);
        flag_chk(1'b0);
        apb(1'b1, ICU_OFS_IRQ_STATUS, 32'h1);
        flag_chk(1'b0);
        apb(1'b0, 8'h3c, 32'h0);
        chk({31'h0, er}, 32'h1);
        lfsr = next_rand(lfsr);
        apb(1'b1, ICU_OFS_VALUE_HIGH, lfsr);
        rchk(ICU_OFS_VALUE_HIGH, {24'h0, lfsr[7:0]});
        $display("test regs done");
        // Single-edge modes: the wrong edge is ignored, the right one captures
        for (int i = 0; i < 2; i++) begin
            lvl = (i == 1);
            edge_to(lvl);
            set_mode(i ? ICU_MODE_RISE : ICU_MODE_FALL);
            edge_to(!lvl);
            flag_chk(1'b0);
            edge_to(lvl);
            flag_chk(1'b1);
            val_chk();
        end
        $display("test edges done");
        // Prescaled modes fire on the 4th and 16th edge only
        for (int i = 0; i < 2; i++) begin
            set_mode(i ? ICU_MODE_RISE16 : ICU_MODE_RISE4);
            rises(i ? 15 : 3);
            flag_chk(1'b0);
            rises(1);
            flag_chk(1'b1);
            val_chk();
        end
        // Direct prescale switch keeps the count: fires on the 14th edge
        set_mode(ICU_MODE_RISE4);
        rises(2);
        apb(1'b1, ICU_OFS_CONTROL, {28'h0, ICU_MODE_RISE16});
        apb(1'b1, ICU_OFS_IRQ_CLEAR, 32'h1);
        rises(13);
        flag_chk(1'b0);
        rises(1);
        flag_chk(1'b1);
        $display("test prescale done");
        // A non-capture mode code, or a reset, clears a part-done prescale count
        for (int k = 0; k < 2; k++) begin
            set_mode(ICU_MODE_RISE4);
            rises(2);
            if (k == 1) begin
                lfsr = next_rand(lfsr);
                @(posedge core_clk);
                preset <= lfsr[15:0];
                rst_n <= 1'b0;
                repeat (2) @(posedge core_clk);
                rst_n <= 1'b1;
            end else begin
                // A non-capture code other than off must clear it too
                apb(1'b1, ICU_OFS_CONTROL, 32'h8);
            end
            // Straight into the mode: only the clear above can reset the count
            apb(1'b1, ICU_OFS_CONTROL, {28'h0, ICU_MODE_RISE4});
            apb(1'b1, ICU_OFS_IRQ_CLEAR, 32'h1);
            rises(3);
            flag_chk(1'b0);
            rises(1);
            flag_chk(1'b1);
            val_chk();
        end
        $display("test clear done");
        // Sticky flag, mask, clear; newer capture overwrites; one per edge
        apb(1'b1, ICU_OFS_IRQ_ENABLE, 32'h1);
        irq_chk(1'b1);
        apb(1'b1, ICU_OFS_IRQ_ENABLE, 32'h0);
        irq_chk(1'b0);
        set_mode(ICU_MODE_RISE);
        apb(1'b1, ICU_OFS_IRQ_ENABLE, 32'h1);
        rises(2);
        irq_chk(1'b1);
        val_chk();
        apb(1'b1, ICU_OFS_IRQ_CLEAR, 32'h1);
        irq_chk(1'b0);
        repeat (20) @(posedge core_clk);
        flag_chk(1'b0);
        rchk(ICU_OFS_IRQ_CLEAR, 32'h0);
        $display("test flag done");
        // Sleep: internal timebase halts and blocks capture; external keeps it
        @(posedge core_clk);
        sleep_active <= 1'b1;
        rises(1);
        chk({31'h0, cnt_en}, 32'h0);
        flag_chk(1'b0);
        @(posedge core_clk);
        ext_clk <= 1'b1;
        rises(1);
        chk({31'h0, cnt_en}, 32'h1);
        flag_chk(1'b1);
        val_chk();
        @(posedge core_clk);
        sleep_active <= 1'b0;
        ext_clk <= 1'b0;
        $display("test sleep done");
        stop_test();
    end
endmodule : input_capture_unit_tb_top
